// file: rtl/ssc_pkg.sv
// constants of the system clock source selector
// assumes one register clock and AXI4-Lite with 32-bit data
package ssc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFS_OSC_TUNE = 4'h4;
  localparam logic [3:0] OFS_TMR1_CTRL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_IDLE = 7;
  localparam int BIT_IFS_HI = 6;
  localparam int BIT_IFS_LO = 4;
  localparam int BIT_STARTUP_TIMEOUT_STATUS = 3;
  localparam int BIT_INTERNAL_FREQ_STABLE = 2;
  localparam int BIT_LFS = 7;
  localparam int BIT_MULT = 6;
  localparam int BIT_SEC_RUN = 6;
  localparam int BIT_SEC_EN = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0] RST_IFS = 3'h4;
  localparam logic [1:0] RST_SCS = 2'h0;
  localparam logic RST_IDLE = 1'b0;

  // ****************************************
  // encodings and timing
  // ****************************************
  localparam logic [3:0] CFG_INT_A = 4'h8;
  localparam logic [3:0] CFG_INT_B = 4'h9;
  localparam logic [2:0] IFS_8MHZ = 3'h7;
  localparam logic [2:0] IFS_31KHZ = 3'h0;
  localparam logic [3:0] DIV_LOG_256 = 4'h8;
  localparam logic [2:0] OLD_TICKS = 3'h2;
  localparam logic [2:0] NEW_TICKS = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    SRC_PRI = 2'b00,
    SRC_SEC = 2'b01,
    SRC_INT = 2'b10
  } ssc_src_e;

  typedef enum logic [1:0]
  {
    SW_IDLE = 2'b00,
    SW_OLD = 2'b01,
    SW_NEW = 2'b10
  } ssc_sw_e;

endpackage : ssc_pkg

// file: rtl/ssc_clock_select.sv
// system clock source selector: register file, glitch-free switch sequencer
// assumes source activity levels arrive asynchronously and are synchronised here
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// three-stage input synchroniser
// ****************************************
module ssc_sync3
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        level_o <= s3_q;
      end
    end
  end
endmodule : ssc_sync3

module ssc_clock_select
  import ssc_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] primary_osc_config_i,
  input wire logic two_speed_startup_config_i,
  input wire logic sleep_req_i,
  input wire logic wake_i,
  input wire logic primary_clk_i,
  input wire logic secondary_clk_i,
  input wire logic internal_clk_i,
  input wire logic ost_expired_i,
  input wire logic fast_osc_stable_i,
  output logic [1:0] active_src_o,
  output logic clk_run_o,
  output logic [3:0] int_div_log_o,
  output logic int_use_rc_o,
  output logic fast_osc_enable_o,
  output logic slow_rc_for_wdt_o,
  output logic freq_mult_enable_o,
  output logic idle_mode_o,
  output logic sleep_mode_o
);

  // ****************************************
  // input synchronisers and tick detect
  // ****************************************
  logic [2:0] src_lvl;
  logic [2:0] src_prev_q;
  logic [2:0] src_tick;
  logic ost_lvl;
  logic fast_lvl;
  logic [4:0] async_in;
  logic [4:0] sync_out;

  assign async_in = {fast_osc_stable_i, ost_expired_i, internal_clk_i, secondary_clk_i,
                     primary_clk_i};
  assign src_lvl = sync_out[2:0];
  assign ost_lvl = sync_out[3];
  assign fast_lvl = sync_out[4];
  assign src_tick = src_lvl & ~src_prev_q;

  for (genvar g = 0; g < 5; g++)
  begin : g_sync
    ssc_sync3 u_sync
    (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(async_in[g]),
      .level_o(sync_out[g])
    );
  end

  // ****************************************
  // register state
  // ****************************************
  logic idle_q;
  logic [2:0] ifs_q;
  logic [1:0] scs_q;
  logic lfs_q;
  logic mult_bit_q;
  logic sec_en_q;
  logic startup_timeout_status_q;
  logic internal_freq_stable_q;
  logic sec_run_q;
  ssc_src_e active_q;
  ssc_sw_e sw_q;
  logic [2:0] cnt_q;
  ssc_src_e target_q;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;

  // ****************************************
  // decode
  // ****************************************
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic do_write;
  logic wr_ctrl;
  logic wr_tune;
  logic wr_tmr1;
  logic pri_is_int;
  logic mult_avail;
  ssc_src_e req_src;
  ssc_src_e want_src;
  logic start_sw;
  logic old_tick;
  logic new_tick;
  logic fast_in_use;
  logic [7:0] ctrl_rd;
  logic [7:0] tune_rd;
  logic [7:0] tmr1_rd;
  logic [7:0] stat_rd;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [3:0] div_log;
  logic w_is_ctrl;
  logic w_is_tune;
  logic w_is_tmr1;
  logic w_is_stat;
  logic r_is_ctrl;
  logic r_is_tune;
  logic r_is_tmr1;
  logic r_is_stat;

  // full address compare, so upper address bits never alias a register
  assign w_is_ctrl = waddr_q == ADDR_W'(OFS_OSC_CTRL);
  assign w_is_tune = waddr_q == ADDR_W'(OFS_OSC_TUNE);
  assign w_is_tmr1 = waddr_q == ADDR_W'(OFS_TMR1_CTRL);
  assign w_is_stat = waddr_q == ADDR_W'(OFS_STATUS);
  assign r_is_ctrl = s_axi_araddr == ADDR_W'(OFS_OSC_CTRL);
  assign r_is_tune = s_axi_araddr == ADDR_W'(OFS_OSC_TUNE);
  assign r_is_tmr1 = s_axi_araddr == ADDR_W'(OFS_TMR1_CTRL);
  assign r_is_stat = s_axi_araddr == ADDR_W'(OFS_STATUS);

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign b_hs = s_axi_bvalid & s_axi_bready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign r_hs = s_axi_rvalid & s_axi_rready;
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_ctrl = do_write & wstrb0_q & w_is_ctrl;
  assign wr_tune = do_write & wstrb0_q & w_is_tune;
  assign wr_tmr1 = do_write & wstrb0_q & w_is_tmr1;

  assign pri_is_int = (primary_osc_config_i == CFG_INT_A) | (primary_osc_config_i == CFG_INT_B);
  assign mult_avail = pri_is_int & (ifs_q[2:1] == 2'b11);
  assign req_src = scs_q[1] ? SRC_INT : (scs_q[0] ? SRC_SEC : SRC_PRI);
  assign want_src = (req_src == SRC_SEC && !sec_en_q) ? active_q : req_src;
  assign start_sw = (sw_q == SW_IDLE) & (want_src != active_q);
  assign old_tick = src_tick[active_q];
  assign new_tick = src_tick[target_q];
  assign fast_in_use = (ifs_q != IFS_31KHZ) | lfs_q;
  assign div_log = (ifs_q == IFS_31KHZ) ? DIV_LOG_256 : {1'b0, IFS_8MHZ - ifs_q};

  assign ctrl_rd = {idle_q, ifs_q, startup_timeout_status_q, internal_freq_stable_q, scs_q};
  assign tune_rd = {lfs_q, mult_bit_q & pri_is_int, 6'h00};
  assign tmr1_rd = {1'b0, sec_run_q, 2'b00, sec_en_q, 3'b000};
  assign stat_rd = {3'b000, idle_mode_o, sleep_mode_o, sw_q != SW_IDLE, active_q};
  assign rd_hit = r_is_ctrl | r_is_tune | r_is_tmr1 | r_is_stat;
  assign rd_byte = r_is_ctrl ? ctrl_rd :
                   r_is_tune ? tune_rd :
                   r_is_tmr1 ? tmr1_rd :
                   r_is_stat ? stat_rd : 8'h00;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        w_have_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (w_is_ctrl | w_is_tune | w_is_tmr1 | w_is_stat) ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_hs)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (ar_hs)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (r_hs)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      idle_q <= RST_IDLE;
      ifs_q <= RST_IFS;
      scs_q <= RST_SCS;
      lfs_q <= 1'b0;
      mult_bit_q <= 1'b0;
      sec_en_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        idle_q <= wbyte_q[BIT_IDLE];
        ifs_q <= wbyte_q[BIT_IFS_HI:BIT_IFS_LO];
        scs_q <= wbyte_q[1:0];
      end
      if (wr_tune)
      begin
        lfs_q <= wbyte_q[BIT_LFS];
        mult_bit_q <= wbyte_q[BIT_MULT];
      end
      if (wr_tmr1)
      begin
        sec_en_q <= wbyte_q[BIT_SEC_EN];
      end
    end
  end

  // ****************************************
  // glitch-free switch sequencer
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      sw_q <= SW_IDLE;
      cnt_q <= 3'h0;
      target_q <= SRC_PRI;
      active_q <= SRC_PRI;
      src_prev_q <= 3'b000;
    end
    else
    begin
      src_prev_q <= src_lvl;
      unique case (sw_q)
        SW_IDLE:
        begin
          if (start_sw)
          begin
            target_q <= want_src;
            cnt_q <= 3'h0;
            sw_q <= SW_OLD;
          end
        end
        SW_OLD:
        begin
          if (old_tick)
          begin
            cnt_q <= (cnt_q == OLD_TICKS - 3'h1) ? 3'h0 : cnt_q + 3'h1;
            if (cnt_q == OLD_TICKS - 3'h1)
            begin
              sw_q <= SW_NEW;
            end
          end
        end
        SW_NEW:
        begin
          if (new_tick)
          begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == NEW_TICKS - 3'h1)
            begin
              active_q <= target_q;
              sw_q <= SW_IDLE;
            end
          end
        end
        default:
        begin
          sw_q <= SW_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // status flags and clock outputs
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      startup_timeout_status_q <= ~two_speed_startup_config_i;
      internal_freq_stable_q <= 1'b0;
      sec_run_q <= 1'b0;
      idle_mode_o <= 1'b0;
      sleep_mode_o <= 1'b0;
      clk_run_o <= 1'b1;
      active_src_o <= SRC_PRI;
      int_div_log_o <= 4'h0;
      int_use_rc_o <= 1'b0;
      fast_osc_enable_o <= 1'b1;
      slow_rc_for_wdt_o <= 1'b1;
      freq_mult_enable_o <= 1'b0;
    end
    else
    begin
      if (sw_q == SW_IDLE)
      begin
        startup_timeout_status_q <= ost_lvl & (active_q == SRC_PRI);
        internal_freq_stable_q <= fast_lvl & fast_in_use & (active_q == SRC_INT);
        sec_run_q <= active_q == SRC_SEC;
      end
      if (sleep_req_i && !idle_mode_o && !sleep_mode_o)
      begin
        idle_mode_o <= idle_q;
        sleep_mode_o <= ~idle_q;
      end
      else if (wake_i)
      begin
        idle_mode_o <= 1'b0;
        sleep_mode_o <= 1'b0;
      end
      clk_run_o <= (sw_q == SW_IDLE) & ~start_sw & ~sleep_mode_o;
      active_src_o <= active_q;
      int_div_log_o <= div_log;
      int_use_rc_o <= (ifs_q == IFS_31KHZ) & ~lfs_q;
      fast_osc_enable_o <= fast_in_use;
      slow_rc_for_wdt_o <= 1'b1;
      freq_mult_enable_o <= mult_bit_q & mult_avail;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_scs_reset: assert property (@(posedge core_clk_i) $past(sys_rst_i) |-> scs_q == 2'b00)
    else $error("source select not cleared by reset");
  a_ifs_reset: assert property (@(posedge core_clk_i) $past(sys_rst_i) |->
    ifs_q == 3'b100 && !idle_q)
    else $error("frequency or idle reset value wrong");
  a_sw_paused: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sw_q != SW_IDLE) |=> !clk_run_o)
    else $error("clock ran during switch");
  a_flags_onehot: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $onehot0({startup_timeout_status_q, internal_freq_stable_q, sec_run_q}))
    else $error("more than one source flag set");
  a_sec_flag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sw_q == SW_IDLE && active_q == SRC_SEC) |=> sec_run_q)
    else $error("secondary running flag missing");
  a_mult_gate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    freq_mult_enable_o |-> $past(pri_is_int) && $past(ifs_q[2:1]) == 2'b11)
    else $error("multiplier enabled outside allowed mode");
  a_sleep_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sleep_req_i && !idle_mode_o && !sleep_mode_o && !wake_i) |=>
    (idle_mode_o == $past(idle_q)) && (sleep_mode_o != $past(idle_q)))
    else $error("sleep mode choice wrong");
  a_flags_frozen: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sw_q != SW_IDLE) |=> $stable({startup_timeout_status_q, internal_freq_stable_q, sec_run_q}))
    else $error("flags changed during switch");
  a_sec_ignored: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (sw_q == SW_IDLE && scs_q == 2'b01 && !sec_en_q && active_q != SRC_SEC) |=>
    target_q != SRC_SEC)
    else $error("secondary chosen without its oscillator");
  a_rc_select: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ifs_q == 3'b000 && !lfs_q) |=> int_use_rc_o && int_div_log_o == 4'h8)
    else $error("low-frequency source wrong");

  c_switch_done: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(sw_q == SW_NEW));
  c_to_internal: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(active_q) && active_q == SRC_INT);
  c_idle_entry: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(idle_mode_o));
  c_sleep_entry: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(sleep_mode_o));

endmodule : ssc_clock_select
`default_nettype wire

// file: sim/test_system_clock_source_select.sv
// self-checking bench of the system clock source selector
// assumes AXI4-Lite answers one cycle after each handshake and slow source activity levels
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end

module test_system_clock_source_select
  import ssc_pkg::*;
;
  localparam int HP = 5;
  localparam int HS = 7;
  localparam int HI = 6;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, tsc, oscillator_startup_timer, fst, slp, wake;
  logic pclk, sclk, iclk, awready, wready, bvalid, arready, rvalid;
  logic run, use_rc, fast_en, wdt, mult, idle_m, sleep_m, lfs, mul, idl;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, cfg, dlog;
  logic [1:0] bresp, rresp, act, cs;
  logic [2:0] ifs;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 64;
  int pc = 0;
  int sc = 0;
  int ic = 0;

  ssc_clock_select #(.ADDR_W(5)) dut
  (
    .core_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .primary_osc_config_i(cfg), .two_speed_startup_config_i(tsc), .sleep_req_i(slp),
    .wake_i(wake), .primary_clk_i(pclk), .secondary_clk_i(sclk), .internal_clk_i(iclk),
    .ost_expired_i(oscillator_startup_timer), .fast_osc_stable_i(fst), .active_src_o(act), .clk_run_o(run),
    .int_div_log_o(dlog), .int_use_rc_o(use_rc), .fast_osc_enable_o(fast_en),
    .slow_rc_for_wdt_o(wdt), .freq_mult_enable_o(mult), .idle_mode_o(idle_m),
    .sleep_mode_o(sleep_m)
  );

  // ****************************************
  // clock and slow source activity levels
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    pc <= (pc + 1) % HP;
    sc <= (sc + 1) % HS;
    ic <= (ic + 1) % HI;
    if (pc == HP - 1) pclk <= !pclk;
    if (sc == HS - 1) sclk <= !sclk;
    if (ic == HI - 1) iclk <= !iclk;
  end

  // ****************************************
  // bus tasks and expectations
  // ****************************************
  function automatic logic [3:0] exp_div(input logic [2:0] f);
    return (f == 3'h0) ? 4'h8 : {1'b0, 3'h7 - f};
  endfunction : exp_div

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      ad = ad | (awvalid & awready);
      wd = wd | (wvalid & wready);
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask : axw

  task automatic axr(input logic [4:0] a, input logic [7:0] ex, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", {24'h000000, ex}, rdata)
    `CHK("rresp", er, rresp)
  endtask : axr

  task automatic wsw(input logic [1:0] ex, input int mn);
    int n, low;
    n = 0;
    low = 0;
    while (n < 600 && !(act === ex && run === 1'b1))
    begin
      @(posedge clk);
      n++;
      low += (run === 1'b0);
    end
    `CHK("active_src", ex, act)
    `CHK("pause_long", 1'b1, low >= mn)
  endtask : wsw

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    `CHK("div_rst", 4'h3, dlog)
    `CHK("src_rst", SRC_PRI, act)
    `CHK("wdt_rst", 1'b1, wdt)
    // start-up flag needs the level through its synchroniser first
    tick(6);
    axr(5'h00, 8'h48, RESP_OKAY);
    axr(5'h04, 8'h00, RESP_OKAY);
  endtask : do_reset

  task automatic test_done();
    $display("errors %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, slp, wake, pclk, sclk, iclk} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    tsc = 1'b0;
    oscillator_startup_timer = 1'b1;
    fst = 1'b1;
    cfg = ($random(seed) % 2 != 0) ? CFG_INT_A : CFG_INT_B;
    do_reset();
    axw(5'h14, 8'hFF, RESP_SLVERR);
    axr(5'h14, 8'h00, RESP_SLVERR);
    cs = {1'b1, 1'($random(seed))};
    axw(5'h00, {4'h4, 2'b00, cs}, RESP_OKAY);
    wsw(SRC_INT, 6 * HI - 4);
    for (int i = 0; i < 12; i++)
    begin
      ifs = (i < 8) ? 3'(i) : 3'($random(seed));
      lfs = 1'($random(seed));
      mul = 1'($random(seed));
      axw(5'h04, {lfs, mul, 6'h00}, RESP_OKAY);
      axw(5'h00, {1'b0, ifs, 2'b00, cs}, RESP_OKAY);
      tick(3);
      `CHK("div_log", exp_div(ifs), dlog)
      `CHK("use_rc", (ifs == 3'h0) && !lfs, use_rc)
      `CHK("fast_en", (ifs != 3'h0) || lfs, fast_en)
      `CHK("mult", mul && (ifs[2:1] == 2'b11), mult)
      `CHK("wdt", 1'b1, wdt)
      axr(5'h04, {lfs, mul, 6'h00}, RESP_OKAY);
      axr(5'h00, {1'b0, ifs, 1'b0, (ifs != 3'h0) || lfs, cs}, RESP_OKAY);
    end
    for (int k = 0; k < 2; k++)
    begin
      idl = (k == 0);
      axw(5'h00, {idl, 3'h4, 2'b00, cs}, RESP_OKAY);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      tick(2);
      `CHK("idle_mode", idl, idle_m)
      `CHK("sleep_mode", !idl, sleep_m)
      if (!idl) `CHK("run_sleep", 1'b0, run)
      axr(5'h0C, {3'b000, idl, !idl, 3'b010}, RESP_OKAY);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      tick(2);
      `CHK("woken", 2'b00, {idle_m, sleep_m})
    end
    axw(5'h0C, 8'hFF, RESP_OKAY);
    axr(5'h0C, 8'h02, RESP_OKAY);
    axw(5'h00, 8'h41, RESP_OKAY);
    tick(60);
    `CHK("sec_refused", SRC_INT, act)
    axw(5'h08, 8'h08, RESP_OKAY);
    axw(5'h00, 8'h41, RESP_OKAY);
    wsw(SRC_SEC, 4 * HS);
    axr(5'h08, 8'h48, RESP_OKAY);
    axr(5'h00, 8'h41, RESP_OKAY);
    axw(5'h00, 8'h40, RESP_OKAY);
    wsw(SRC_PRI, 4 * HP);
    axr(5'h08, 8'h08, RESP_OKAY);
    axr(5'h00, 8'h48, RESP_OKAY);
    axw(5'h04, 8'h80, RESP_OKAY);
    axw(5'h00, {4'h4, 2'b00, cs}, RESP_OKAY);
    tick(5);
    do_reset();
    test_done();
  end

endmodule : test_system_clock_source_select
`default_nettype wire
